// File: src/protection_and_calibration_control.sv
// Protection latch, error queue, security and calibration sequencing behind an APB slave.
// Assumes fault levels and stop button are synchronous to clk_sys; one clock domain.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "prot_cal_cfg.svh"

// Notes on behaviour
// - Stop button or abort ends test, keeps data
// - Fault latches output off until cleared
// - Alarm weights: OV 1, OC 2, UV 512
// - Alarm event read returns and clears
// - Condition reads show live faults
// - Protection clear drops latch and error light
// - Error light only on protection events
// - Command errors queue, operation continues
// - Error read pops one; empty reads zero
// - Date text up to 16, empty allowed
// - Load restores previous constants until store
// - Result entry returns zero or queues error
// - Secured refuses calibration, text, code changes
// - Factory unsecured, code zero; state 0/1
// - Start resets, closes relays, disables protections
// - Steps 1-3, reset each, query zero default
// - Store overwrites nonvolatile constants
// - Message up to 128, readable when secured
// - Constant query per step 1-3
module protection_and_calibration_control
  import prot_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel and fault sensing
  input wire logic stopButton,
  input wire fault_t faults,
  output logic errorLed,
  // Test engine
  input wire logic testStart,
  output logic testRunning,
  output logic outputEnable,
  // Command parser errors
  input wire err_push_t parserError,
  // Calibration hardware
  output logic relaysClosed,
  output logic protectionEnabled,
  output logic [15:0] converterSetpoint,
  output logic calStepReset,
  output logic instrumentReset
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic setupPhase, wrAccess, rdAccess, mapped;
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_STRING_IDX);

  logic [31:0] ctl;
  assign ctl = (wrAccess && paddr == `OFS_CONTROL) ? pwdata : 32'h0000_0000;

  // ****************************************
  // State declarations
  // ****************************************
  logic protLatched, calMode, stored, secured;
  cal_state_t calState;
  logic [31:0] alarmEvent, readAlarm;
  logic [1:0] calStep;
  logic [31:0] calWork [1:3];
  logic [31:0] calPrev [1:3];
  logic [31:0] calNv [1:3];
  logic [31:0] resultCode;
  logic [127:0] secCode, codeStage;
  logic [7:0] dateMem [0:`DATE_LEN_MAX-1];
  logic [4:0] dateLen;
  logic [3:0] datePtr;
  logic [7:0] strMem [0:`STRING_LEN_MAX-1];
  logic [7:0] strLen;
  logic [6:0] strPtr;
  logic [15:0] errMem [0:`ERR_DEPTH-1];
  logic [`ERR_PTR_W-1:0] errRd, errWr;
  logic [`ERR_PTR_W:0] errCount;
  err_push_t errPush;
  logic faultNow, errPop;

  assign faultNow = faults.overVoltageFault || faults.underVoltageFault || faults.overCurrentFault;
  assign calMode = (calState != CAL_IDLE);
  assign protectionEnabled = !calMode;
  assign errorLed = protLatched;
  assign outputEnable = testRunning && !protLatched;

  // ****************************************
  // Command checks
  // ****************************************
  logic wrStep, wrResult, wrDate, wrStr, wrCodeWord;
  logic stepOk, resultOk, refuse;
  assign wrStep = wrAccess && paddr == `OFS_CAL_STEP;
  assign wrResult = wrAccess && paddr == `OFS_CAL_RESULT;
  assign wrDate = wrAccess && paddr == `OFS_DATE;
  assign wrStr = wrAccess && paddr == `OFS_STRING;
  assign wrCodeWord = wrAccess && paddr == `OFS_SEC_CODE;
  assign stepOk = calMode && pwdata >= 32'h1 && pwdata <= {30'h0, `CAL_STEP_MAX};
  // A result needs a live step to land on
  assign resultOk = calMode && calStep != 2'h0;
  // Any calibration-side change while secured is refused
  assign refuse = secured && (ctl[`CTL_CAL_START] || ctl[`CTL_CAL_END] || ctl[`CTL_CAL_LOAD] ||
    ctl[`CTL_CAL_STORE] || ctl[`CTL_SET_CODE] || ctl[`CTL_DATE_CLEAR] || ctl[`CTL_STRING_CLEAR] ||
    wrStep || wrResult || wrDate || wrStr);

  // ****************************************
  // Error sources, one push per cycle
  // ****************************************
  always_comb begin
    errPush = '{valid: 1'b0, code: `ERR_NONE};
    if (refuse) begin
      errPush = '{valid: 1'b1, code: `ERR_SECURED};
    end else if (wrStep && !stepOk) begin
      errPush = '{valid: 1'b1, code: `ERR_BAD_STEP};
    end else if (wrResult && !resultOk) begin
      errPush = '{valid: 1'b1, code: `ERR_RESULT};
    end else if (ctl[`CTL_CAL_LOAD] && stored) begin
      errPush = '{valid: 1'b1, code: `ERR_LOAD_AFTER_STORE};
    end else if (ctl[`CTL_UNSECURE] && secured && codeStage != secCode) begin
      errPush = '{valid: 1'b1, code: `ERR_BAD_CODE};
    end else if (!calMode && (ctl[`CTL_CAL_END] || ctl[`CTL_CAL_STORE])) begin
      errPush = '{valid: 1'b1, code: `ERR_NOT_CAL};
    end else if (parserError.valid) begin
      errPush = parserError;
    end
  end

  // ****************************************
  // Error queue
  // ****************************************
  // Full queue drops the newest error rather than stalling anything
  assign errPop = rdAccess && paddr == `OFS_ERROR && errCount != '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      errRd <= '0;
      errWr <= '0;
      errCount <= '0;
    end else begin
      if (errPop) begin
        errRd <= errRd + 1'b1;
      end
      if (errPush.valid && errCount != `ERR_DEPTH) begin
        errWr <= errWr + 1'b1;
      end
      errCount <= errCount + {3'h0, errPush.valid && errCount != `ERR_DEPTH} - {3'h0, errPop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (errPush.valid && errCount != `ERR_DEPTH) begin
      errMem[errWr] <= errPush.code;
    end
  end

  // ****************************************
  // Test run and protection
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      testRunning <= 1'b0;
    end else if (stopButton || ctl[`CTL_ABORT] || (ctl[`CTL_CAL_START] && !secured)) begin
      testRunning <= 1'b0;
    end else if (testStart && !protLatched && !calMode) begin
      testRunning <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      protLatched <= 1'b0;
    end else if (faultNow && protectionEnabled) begin
      protLatched <= 1'b1;
    end else if (ctl[`CTL_PROT_CLEAR] && !faultNow) begin
      protLatched <= 1'b0;
    end
  end

  // Clear only the bits returned, so an event in the read cycle survives
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarmEvent <= 32'h0000_0000;
    end else begin
      alarmEvent <= (alarmEvent & ~((rdAccess && paddr == `OFS_ALARM_EVENT) ? readAlarm : 32'h0)) |
        (faults.overVoltageFault ? `ALM_OVER_VOLTAGE : 32'h0) |
        (faults.overCurrentFault ? `ALM_OVER_CURRENT : 32'h0) |
        (faults.underVoltageFault ? `ALM_UNDER_VOLTAGE : 32'h0);
    end
  end

  // ****************************************
  // Calibration sequence
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      calState <= CAL_IDLE;
      calStep <= 2'h0;
      stored <= 1'b0;
      relaysClosed <= 1'b0;
      converterSetpoint <= 16'h0000;
      calStepReset <= 1'b0;
      instrumentReset <= 1'b0;
      resultCode <= 32'h0000_0000;
    end else begin
      calStepReset <= 1'b0;
      instrumentReset <= 1'b0;
      if (!refuse) begin
        if (ctl[`CTL_CAL_START]) begin
          calState <= CAL_ACTIVE;
          instrumentReset <= 1'b1;
          relaysClosed <= 1'b1;
          converterSetpoint <= `CAL_SETPOINT_3V5;
          calStep <= 2'h0;
          stored <= 1'b0;
        end else if (ctl[`CTL_CAL_END] && calMode) begin
          calState <= CAL_ENDED;
        end else if (wrStep && stepOk) begin
          calStep <= pwdata[1:0];
          calStepReset <= 1'b1;
        end
        if (ctl[`CTL_CAL_STORE] && calMode) begin
          stored <= 1'b1;
          calState <= CAL_IDLE;
          relaysClosed <= 1'b0;
          converterSetpoint <= 16'h0000;
        end
        if (wrResult) begin
          resultCode <= resultOk ? 32'h0 : {16'h0, `ERR_RESULT};
        end
      end
      case (calState)
        CAL_IDLE, CAL_ACTIVE, CAL_ENDED: ;
        default: calState <= CAL_IDLE;
      endcase
    end
  end

  // Work copy, undo copy and stored copy of the constants
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= 3; i++) begin
        calWork[i] <= 32'h0;
        calPrev[i] <= 32'h0;
        calNv[i] <= 32'h0;
      end
    end else if (!refuse) begin
      if (ctl[`CTL_CAL_START]) begin
        for (int i = 1; i <= 3; i++) begin
          calPrev[i] <= calNv[i];
          calWork[i] <= calNv[i];
        end
      end else if (ctl[`CTL_CAL_LOAD] && !stored) begin
        for (int i = 1; i <= 3; i++) begin
          calWork[i] <= calPrev[i];
        end
      end else if (ctl[`CTL_CAL_STORE] && calMode) begin
        for (int i = 1; i <= 3; i++) begin
          calNv[i] <= calWork[i];
          calPrev[i] <= calWork[i];
        end
      end else if (wrResult && resultOk) begin
        calWork[calStep] <= pwdata;
      end
    end
  end

  // ****************************************
  // Security
  // ****************************************
  // Code shifts in 32 bits per write, most significant word first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      codeStage <= 128'h0;
      secCode <= 128'h0;
      secured <= 1'b0;
    end else begin
      if (wrCodeWord) begin
        codeStage <= {codeStage[95:0], pwdata};
      end
      if (ctl[`CTL_SET_CODE] && !secured) begin
        secCode <= codeStage;
      end
      if (ctl[`CTL_SECURE]) begin
        secured <= 1'b1;
      end else if (ctl[`CTL_UNSECURE] && codeStage == secCode) begin
        secured <= 1'b0;
      end
    end
  end

  // ****************************************
  // Date and message text
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dateLen <= 5'h0;
      datePtr <= 4'h0;
      strLen <= 8'h0;
      strPtr <= 7'h0;
    end else begin
      if (wrAccess && paddr == `OFS_DATE_IDX) begin
        datePtr <= pwdata[3:0];
      end else if (wrDate && !secured) begin
        datePtr <= datePtr + 1'b1;
        dateLen <= ({1'b0, datePtr} >= dateLen) ? {1'b0, datePtr} + 5'h1 : dateLen;
      end else if (ctl[`CTL_DATE_CLEAR] && !secured) begin
        dateLen <= 5'h0;
        datePtr <= 4'h0;
      end
      if (wrAccess && paddr == `OFS_STRING_IDX) begin
        strPtr <= pwdata[6:0];
      end else if (wrStr && !secured) begin
        strPtr <= strPtr + 1'b1;
        strLen <= ({1'b0, strPtr} >= strLen) ? {1'b0, strPtr} + 8'h1 : strLen;
      end else if (ctl[`CTL_STRING_CLEAR] && !secured) begin
        strLen <= 8'h0;
        strPtr <= 7'h0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wrDate && !secured) begin
      dateMem[datePtr] <= pwdata[7:0];
    end
    if (wrStr && !secured) begin
      strMem[strPtr] <= pwdata[7:0];
    end
  end

  // ****************************************
  // Read mux, captured in the setup cycle
  // ****************************************
  logic [31:0] next_prdata;
  logic [31:0] statusWord;
  assign statusWord = {23'h0, relaysClosed, protectionEnabled, secured, stored,
    calState == CAL_ENDED, calMode, errorLed, protLatched, testRunning};

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_STATUS: next_prdata = statusWord;
      `OFS_ALARM_EVENT: next_prdata = alarmEvent;
      `OFS_COND_CURRENT: next_prdata = {31'h0, faults.overCurrentFault};
      `OFS_COND_VOLTAGE: next_prdata = {31'h0, faults.overVoltageFault};
      `OFS_COND_UNDER: next_prdata = {31'h0, faults.underVoltageFault};
      `OFS_ERROR: next_prdata = (errCount != '0) ? {16'h0, errMem[errRd]} : 32'h0;
      `OFS_CAL_STEP: next_prdata = {30'h0, calStep};
      `OFS_CAL_RESULT: next_prdata = resultCode;
      `OFS_CAL_CONST1: next_prdata = calNv[1];
      `OFS_CAL_CONST2: next_prdata = calNv[2];
      `OFS_CAL_CONST3: next_prdata = calNv[3];
      `OFS_SEC_STATE: next_prdata = {31'h0, secured};
      `OFS_DATE: next_prdata = {19'h0, dateLen, ({1'b0, datePtr} < dateLen) ? dateMem[datePtr] : 8'h00};
      `OFS_DATE_IDX: next_prdata = {28'h0, datePtr};
      `OFS_STRING: next_prdata = {16'h0, strLen, ({1'b0, strPtr} < strLen) ? strMem[strPtr] : 8'h00};
      `OFS_STRING_IDX: next_prdata = {25'h0, strPtr};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      readAlarm <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0 : next_prdata;
      readAlarm <= alarmEvent;
      pslverr <= !mapped;
    end
  end

endmodule
`default_nettype wire

// File: src/prot_cal_cfg.svh
// Offsets, field positions, reset values and codes for the protection and calibration controller.
// Assumes a 32-bit APB with byte addresses; included by bare name.
`ifndef PROT_CAL_CFG_SVH
`define PROT_CAL_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ALARM_EVENT 8'h08
`define OFS_COND_CURRENT 8'h0C
`define OFS_COND_VOLTAGE 8'h10
`define OFS_COND_UNDER 8'h14
`define OFS_ERROR 8'h18
`define OFS_CAL_STEP 8'h1C
`define OFS_CAL_RESULT 8'h20
`define OFS_CAL_CONST1 8'h24
`define OFS_CAL_CONST2 8'h28
`define OFS_CAL_CONST3 8'h2C
`define OFS_SEC_CODE 8'h30
`define OFS_SEC_STATE 8'h34
`define OFS_DATE 8'h38
`define OFS_DATE_IDX 8'h3C
`define OFS_STRING 8'h40
`define OFS_STRING_IDX 8'h44

// ****************************************
// Control register bits (write one to act)
// ****************************************
`define CTL_ABORT 0
`define CTL_PROT_CLEAR 1
`define CTL_CAL_START 2
`define CTL_CAL_END 3
`define CTL_CAL_LOAD 4
`define CTL_CAL_STORE 5
`define CTL_SET_CODE 6
`define CTL_SECURE 7
`define CTL_UNSECURE 8
`define CTL_DATE_CLEAR 9
`define CTL_STRING_CLEAR 10

// ****************************************
// Status register bits
// ****************************************
`define STS_TEST_RUNNING 0
`define STS_PROT_LATCHED 1
`define STS_ERROR_LED 2
`define STS_CAL_MODE 3
`define STS_CAL_ENDED 4
`define STS_STORED 5
`define STS_SECURED 6
`define STS_PROT_ENABLED 7
`define STS_RELAYS_CLOSED 8

// ****************************************
// Alarm event weights
// ****************************************
`define ALM_OVER_VOLTAGE 32'h0000_0001
`define ALM_OVER_CURRENT 32'h0000_0002
`define ALM_UNDER_VOLTAGE 32'h0000_0200

// ****************************************
// Sizes, codes and reset values
// ****************************************
`define ERR_DEPTH 8
`define ERR_PTR_W 3
`define DATE_LEN_MAX 16
`define STRING_LEN_MAX 128
`define CODE_WORDS 4
`define CAL_SETPOINT_3V5 16'h8CCD
`define CAL_STEP_MAX 2'h3
`define ERR_NONE 16'h0000
`define ERR_SECURED 16'h0001
`define ERR_BAD_STEP 16'h0002
`define ERR_RESULT 16'h0003
`define ERR_LOAD_AFTER_STORE 16'h0004
`define ERR_BAD_CODE 16'h0005
`define ERR_NOT_CAL 16'h0006

`endif

// File: src/prot_cal_pkg.sv
// Types shared by the protection and calibration controller and its bench.
// Constants live in prot_cal_cfg.svh.
package prot_cal_pkg;

  typedef struct packed {
    logic overVoltageFault;
    logic underVoltageFault;
    logic overCurrentFault;
  } fault_t;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } err_push_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_ACTIVE = 2'b01,
    CAL_ENDED = 2'b10
  } cal_state_t;

endpackage

// File: tb/prot_cal_sva.sv
// ****
// Port checks for the protection and calibration controller
// ****
// Assumes one clock domain, asynchronous active-low reset, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
`include "prot_cal_cfg.svh"
module prot_cal_sva
  import prot_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel, faults, test
  input wire logic stopButton,
  input wire fault_t faults,
  input wire logic errorLed,
  input wire logic testStart,
  input wire logic testRunning,
  input wire logic outputEnable,
  input wire err_push_t parserError,
  // Calibration
  input wire logic relaysClosed,
  input wire logic protectionEnabled,
  input wire logic [15:0] converterSetpoint,
  input wire logic calStepReset,
  input wire logic instrumentReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_READY: assert property (psel && penable |-> pready) else $error("access without ready");
  AST_UNMAP: assert property (psel && !penable && paddr > 8'h44 |=> pslverr && prdata == 32'h0) else $error("unmapped ok");
  AST_STOP: assert property (stopButton |=> !testRunning) else $error("stop ignored");
  AST_LATCH: assert property (protectionEnabled && (|faults) |=> errorLed) else $error("fault not latched");
  AST_OUTEN: assert property (outputEnable == (testRunning && !errorLed)) else $error("output on while latched");
  AST_PARSER: assert property (parserError.valid && !errorLed && !(|faults) |=> !errorLed) else $error("led on error");
  AST_CLEAR: assert property (psel && penable && pwrite && paddr == `OFS_CONTROL && pwdata[`CTL_PROT_CLEAR]
    && !(|faults) |=> !errorLed) else $error("clear kept led");
  AST_CALSTART: assert property (instrumentReset |-> ##[0:1] (!protectionEnabled && relaysClosed
    && converterSetpoint == 16'h8CCD)) else $error("cal start setup");
  AST_STEPRST: assert property (calStepReset |-> !protectionEnabled) else $error("step outside cal");
endmodule
bind protection_and_calibration_control prot_cal_sva u_sva (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .stopButton, .faults, .errorLed, .testStart, .testRunning, .outputEnable,
  .parserError, .relaysClosed, .protectionEnabled, .converterSetpoint, .calStepReset, .instrumentReset);
`default_nettype wire

// File: tb/far_side_model.sv
// ****
// Panel, sensors, test engine and parser seen from the controller
// ****
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import prot_cal_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Stimulus
  output var logic stopButton = 1'b0,
  output var fault_t faults = '0,
  output var logic testStart = 1'b0,
  output var err_push_t parserError = '0
);
  // Faults are levels; they hold until changed, like a real cell fault
  task automatic fault(input fault_t f);
    @(posedge clk_sys);
    faults <= f;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic start();
    @(posedge clk_sys);
    testStart <= 1'b1;
    @(posedge clk_sys);
    testStart <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic press();
    @(posedge clk_sys);
    stopButton <= 1'b1;
    @(posedge clk_sys);
    stopButton <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic push(input logic [15:0] c);
    @(posedge clk_sys);
    parserError <= '{1'b1, c};
    @(posedge clk_sys);
    parserError <= '0;
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_protection_and_calibration_control.sv
// ****
// Self-checking bench for the protection and calibration controller
// ****
// Assumes APB answers in one access cycle; far side driven through far_side_model.
`timescale 1ns/1ps
`default_nettype none
`include "prot_cal_cfg.svh"
module tb_protection_and_calibration_control;
  import prot_cal_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, errorLed, testRunning, outputEnable, relaysClosed, protectionEnabled;
  logic calStepReset, instrumentReset, stopButton, testStart;
  logic [15:0] converterSetpoint;
  fault_t faults;
  err_push_t parserError;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] wgt [3] = '{32'h1, 32'h200, 32'h2};
  logic [7:0] cnd [3] = '{`OFS_COND_VOLTAGE, `OFS_COND_UNDER, `OFS_COND_CURRENT};
  always #2 clk_sys = ~clk_sys;
  protection_and_calibration_control u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .stopButton, .faults, .errorLed, .testStart, .testRunning, .outputEnable,
    .parserError, .relaysClosed, .protectionEnabled, .converterSetpoint, .calStepReset, .instrumentReset);
  far_side_model u_far (.clk_sys, .stopButton, .faults, .testStart, .parserError);
  task automatic results();
    $display("Compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Code is shifted in most significant word first
  task automatic stage(input logic [31:0] c);
    for (int i = 0; i < 4; i++) wr(`OFS_SEC_CODE, (i == 3) ? c : 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc(`OFS_STATUS, 32'h80);
    rc(`OFS_SEC_STATE, 32'h0);
    rc(`OFS_ERROR, 32'h0);
    rc(`OFS_CAL_STEP, 32'h0);
    rc(`OFS_DATE, 32'h0);
    rc(8'h48, 32'h0);
    chk(err, 32'h1);
    u_far.start();
    chk(testRunning, 32'h1);
    u_far.press();
    chk(testRunning, 32'h0);
    u_far.start();
    wr(`OFS_CONTROL, 32'h1 << `CTL_ABORT);
    rc(`OFS_STATUS, 32'h80);
    for (int i = 0; i < 3; i++) begin
      u_far.start();
      u_far.fault(fault_t'(3'b100 >> i));
      chk(errorLed, 32'h1);
      chk(outputEnable, 32'h0);
      rc(cnd[i], 32'h1);
      rc(`OFS_ALARM_EVENT, wgt[i]);
      u_far.fault(3'b000);
      rc(`OFS_ALARM_EVENT, wgt[i]);
      rc(`OFS_ALARM_EVENT, 32'h0);
      rc(cnd[i], 32'h0);
      u_far.start();
      chk(outputEnable, 32'h0);
      // Clear only once the condition reads zero
      wr(`OFS_CONTROL, 32'h1 << `CTL_PROT_CLEAR);
      chk(errorLed, 32'h0);
    end
    u_far.push(16'h0077);
    u_far.push(16'h0078);
    chk(errorLed, 32'h0);
    rc(`OFS_ERROR, 32'h77);
    rc(`OFS_ERROR, 32'h78);
    rc(`OFS_ERROR, 32'h0);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_START);
    rc(`OFS_STATUS, 32'h108);
    chk(converterSetpoint, 32'h8CCD);
    wr(`OFS_CAL_STEP, 32'h2);
    rc(`OFS_CAL_STEP, 32'h2);
    wr(`OFS_CAL_STEP, 32'h4);
    wr(`OFS_CAL_RESULT, 32'h1234);
    rc(`OFS_CAL_RESULT, 32'h0);
    // End before store, as the host must
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_END);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_STORE);
    rc(`OFS_CAL_CONST2, 32'h1234);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_LOAD);
    rc(`OFS_CAL_CONST2, 32'h1234);
    // Result outside calibration must fail and queue an error
    wr(`OFS_CAL_RESULT, 32'h1);
    rc(`OFS_CAL_RESULT, 32'h3);
    rc(`OFS_ERROR, `ERR_BAD_STEP);
    rc(`OFS_ERROR, `ERR_LOAD_AFTER_STORE);
    rc(`OFS_ERROR, `ERR_RESULT);
    wr(`OFS_DATE, 32'h41);
    wr(`OFS_DATE_IDX, 32'h0);
    rc(`OFS_DATE, 32'h141);
    stage(32'h5);
    wr(`OFS_CONTROL, 32'h1 << `CTL_SET_CODE);
    wr(`OFS_CONTROL, 32'h1 << `CTL_SECURE);
    rc(`OFS_SEC_STATE, 32'h1);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_START);
    rc(`OFS_STATUS, 32'hE0);
    rc(`OFS_ERROR, `ERR_SECURED);
    rc(`OFS_CAL_CONST2, 32'h1234);
    wr(`OFS_STRING, 32'h5A);
    rc(`OFS_STRING, 32'h0);
    rc(`OFS_ERROR, `ERR_SECURED);
    stage(32'h6);
    wr(`OFS_CONTROL, 32'h1 << `CTL_UNSECURE);
    rc(`OFS_SEC_STATE, 32'h1);
    rc(`OFS_ERROR, `ERR_BAD_CODE);
    stage(32'h5);
    wr(`OFS_CONTROL, 32'h1 << `CTL_UNSECURE);
    rc(`OFS_SEC_STATE, 32'h0);
    wr(`OFS_STRING, 32'h5A);
    wr(`OFS_STRING_IDX, 32'h0);
    rc(`OFS_STRING, 32'h15A);
    // Load before store undoes a bad result
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_START);
    wr(`OFS_CAL_STEP, 32'h2);
    wr(`OFS_CAL_RESULT, 32'h99);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_LOAD);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_END);
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL_STORE);
    rc(`OFS_CAL_CONST2, 32'h1234);
    rc(`OFS_ERROR, 32'h0);
    results();
  end
endmodule
`default_nettype wire
